// ---- core/psrb_pkg.sv ----
package psrb_pkg;

    localparam int NUM_CNT = 9;
    localparam int NUM_REMOTE_MEMORY_ACCESS_STATS = 7;
    localparam int NUM_FC = 9;
    localparam int NUM_IB = 8;
    localparam int CLR_WIDTH = 16;

    localparam logic [7:0] RESP_TYPE_CODE = 8'haf;
    localparam logic [15:0] RESP_CODE_OK = 16'h0000;
    localparam logic [15:0] RESP_CODE_FAILED = 16'h0001;
    localparam logic [15:0] REASON_NONE = 16'h0000;

    localparam logic [6:0] FIRST_BYTE = 7'h10;
    localparam logic [6:0] FAIL_LAST_BYTE = 7'h13;
    localparam logic [6:0] FC_LAST_BYTE = 7'h3b;
    localparam logic [6:0] REMOTE_MEMORY_ACCESS_STATS_LAST_BYTE = 7'h4f;
    localparam logic [6:0] SIZES_BYTE = 7'h15;
    localparam logic [6:0] CLR_HI_BYTE = 7'h16;
    localparam logic [6:0] CLR_LO_BYTE = 7'h17;
    localparam logic [4:0] CODE_WORD = 5'h04;
    localparam logic [4:0] FIELD_WORD = 5'h05;
    localparam logic [4:0] FIRST_CNT_WORD = 5'h06;

    typedef enum logic [1:0] {KIND_FAIL, KIND_REMOTE_MEMORY_ACCESS_STATS, KIND_FC} psrb_kind_type;
    typedef enum logic {ST_IDLE, ST_RUN} psrb_state_type;

    typedef struct packed {
        logic [NUM_CNT-1:0][63:0] value;
    } psrb_cnt_type;

    typedef struct packed {
        logic [7:0] data;
        logic [6:0] offset;
        logic last;
    } psrb_byte_type;

endpackage : psrb_pkg

// ---- core/psrb_builder.sv ----
`timescale 1ns/100ps
module psrb_builder #(
    parameter logic [7:0] STATS_REMOTE_MEMORY_ACCESS_STATS = 8'h01,
    parameter logic [7:0] STATS_FC = 8'h02
) (
    input wire logic i_clock,
    input wire logic i_rst_b,
    input wire logic i_req,
    input wire logic [7:0] i_req_type,
    input wire logic i_req_fail,
    input wire logic [15:0] i_req_reason,
    input wire psrb_pkg::psrb_cnt_type i_counters,
    input wire logic [psrb_pkg::NUM_REMOTE_MEMORY_ACCESS_STATS-1:0] i_remote_memory_access_stats_size64,
    input wire logic [psrb_pkg::NUM_REMOTE_MEMORY_ACCESS_STATS-1:0] i_clr_remote_memory_access_stats,
    input wire logic [psrb_pkg::NUM_FC-1:0] i_clr_fc,
    input wire logic [psrb_pkg::NUM_IB-1:0] i_clr_ib,
    input wire logic i_ib_reported,
    input wire logic i_ready,
    output logic o_busy,
    output logic o_valid,
    output psrb_pkg::psrb_byte_type o_byte,
    output logic [7:0] o_resp_type,
    output logic [psrb_pkg::CLR_WIDTH-1:0] o_ib_cleared
);

    psrb_pkg::psrb_state_type state_reg, state_next;
    psrb_pkg::psrb_kind_type kind_reg, kind_next;
    psrb_pkg::psrb_cnt_type snap_reg, snap_next;
    logic [6:0] off_reg, off_next;
    logic [7:0] stype_reg, stype_next;
    logic [15:0] reason_reg, reason_next;
    logic [6:0] size_reg, size_next;
    logic [15:0] clr_snap_reg, clr_snap_next;
    logic [psrb_pkg::NUM_REMOTE_MEMORY_ACCESS_STATS-1:0] remote_memory_access_stats_flag_reg, remote_memory_access_stats_flag_next;
    logic [psrb_pkg::NUM_FC-1:0] fc_flag_reg, fc_flag_next;
    logic [psrb_pkg::NUM_IB-1:0] ib_flag_reg, ib_flag_next;
    logic busy_reg, busy_next;
    logic valid_reg, valid_next;
    psrb_pkg::psrb_byte_type byte_reg, byte_next;
    psrb_pkg::psrb_kind_type out_kind_reg, out_kind_next;
    logic [7:0] resp_type_reg;
    logic accept;
    logic advance;
    logic [6:0] last_off;

    // Picks one big-endian byte of the response from the snapshot.
    function automatic logic [7:0] pick(input logic [6:0] off);
        logic [4:0] word;
        logic [4:0] idx;
        logic [63:0] cnt;
        logic [31:0] w32;
        word = off[6:2];
        idx = word - psrb_pkg::FIRST_CNT_WORD;
        cnt = '0;
        w32 = '0;
        if (word == psrb_pkg::CODE_WORD) begin
            if (kind_reg == psrb_pkg::KIND_FAIL) begin
                w32 = {psrb_pkg::RESP_CODE_FAILED, reason_reg};
            end else begin
                w32 = {psrb_pkg::RESP_CODE_OK, psrb_pkg::REASON_NONE};
            end
        end else if (word == psrb_pkg::FIELD_WORD) begin
            if (kind_reg == psrb_pkg::KIND_REMOTE_MEMORY_ACCESS_STATS) begin
                w32 = {stype_reg, 1'b0, size_reg, clr_snap_reg};
            end else begin
                w32 = {stype_reg, 8'h00, clr_snap_reg};
            end
        end else if (kind_reg == psrb_pkg::KIND_REMOTE_MEMORY_ACCESS_STATS) begin
            cnt = snap_reg.value[idx[4:1]];
            // A 32-bit counter shows an empty upper word.
            w32 = idx[0] ? cnt[31:0] : (size_reg[idx[3:1]] ? cnt[63:32] : 32'h0000_0000);
        end else begin
            cnt = snap_reg.value[idx[3:0]];
            w32 = cnt[31:0];
        end
        unique case (off[1:0])
            2'h0: pick = w32[31:24];
            2'h1: pick = w32[23:16];
            2'h2: pick = w32[15:8];
            default: pick = w32[7:0];
        endcase
    endfunction : pick

    always_comb begin
        unique case (kind_reg)
            psrb_pkg::KIND_REMOTE_MEMORY_ACCESS_STATS: last_off = psrb_pkg::REMOTE_MEMORY_ACCESS_STATS_LAST_BYTE;
            psrb_pkg::KIND_FC: last_off = psrb_pkg::FC_LAST_BYTE;
            default: last_off = psrb_pkg::FAIL_LAST_BYTE;
        endcase
    end

    assign accept = (state_reg == psrb_pkg::ST_IDLE) && i_req;
    assign advance = (state_reg == psrb_pkg::ST_RUN) && (!valid_reg || i_ready);

    // Request capture and byte sequencing.
    always_comb begin
        state_next = state_reg;
        kind_next = kind_reg;
        snap_next = snap_reg;
        off_next = off_reg;
        stype_next = stype_reg;
        reason_next = reason_reg;
        size_next = size_reg;
        clr_snap_next = clr_snap_reg;
        if (accept) begin
            state_next = psrb_pkg::ST_RUN;
            off_next = psrb_pkg::FIRST_BYTE;
            stype_next = i_req_type;
            reason_next = i_req_reason;
            snap_next = i_counters;
            size_next = i_remote_memory_access_stats_size64;
            clr_snap_next = '0;
            if (i_req_fail) begin
                kind_next = psrb_pkg::KIND_FAIL;
            end else if (i_req_type == STATS_REMOTE_MEMORY_ACCESS_STATS) begin
                kind_next = psrb_pkg::KIND_REMOTE_MEMORY_ACCESS_STATS;
                clr_snap_next[psrb_pkg::NUM_REMOTE_MEMORY_ACCESS_STATS-1:0] = remote_memory_access_stats_flag_reg;
            end else if (i_req_type == STATS_FC) begin
                kind_next = psrb_pkg::KIND_FC;
                clr_snap_next[psrb_pkg::NUM_FC-1:0] = fc_flag_reg;
            end else begin
                kind_next = psrb_pkg::KIND_FAIL;
            end
        end else if (advance) begin
            off_next = off_reg + 7'h01;
            if (off_reg == last_off) begin
                state_next = psrb_pkg::ST_IDLE;
            end
        end
    end

    // A flag reported in this response drops, but a clear in the same cycle wins.
    always_comb begin
        remote_memory_access_stats_flag_next = remote_memory_access_stats_flag_reg;
        fc_flag_next = fc_flag_reg;
        ib_flag_next = ib_flag_reg;
        if (accept && !i_req_fail && i_req_type == STATS_REMOTE_MEMORY_ACCESS_STATS) begin
            remote_memory_access_stats_flag_next = '0;
        end
        if (accept && !i_req_fail && i_req_type == STATS_FC) begin
            fc_flag_next = '0;
        end
        if (i_ib_reported) begin
            ib_flag_next = '0;
        end
        remote_memory_access_stats_flag_next = remote_memory_access_stats_flag_next | i_clr_remote_memory_access_stats;
        fc_flag_next = fc_flag_next | i_clr_fc;
        ib_flag_next = ib_flag_next | i_clr_ib;
    end

    // Output stage: one byte held until the consumer takes it.
    always_comb begin
        valid_next = valid_reg;
        byte_next = byte_reg;
        out_kind_next = out_kind_reg;
        busy_next = (state_next == psrb_pkg::ST_RUN);
        if (advance) begin
            valid_next = 1'b1;
            byte_next.data = pick(off_reg);
            byte_next.offset = off_reg;
            byte_next.last = (off_reg == last_off);
            out_kind_next = kind_reg;
        end else if (i_ready) begin
            valid_next = 1'b0;
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            state_reg <= psrb_pkg::ST_IDLE;
            kind_reg <= psrb_pkg::KIND_FAIL;
            snap_reg <= '0;
            off_reg <= psrb_pkg::FIRST_BYTE;
            stype_reg <= 8'h00;
            reason_reg <= psrb_pkg::REASON_NONE;
            size_reg <= 7'h00;
            clr_snap_reg <= 16'h0000;
            remote_memory_access_stats_flag_reg <= '0;
            fc_flag_reg <= '0;
            ib_flag_reg <= '0;
            busy_reg <= 1'b0;
            valid_reg <= 1'b0;
            byte_reg <= '0;
            out_kind_reg <= psrb_pkg::KIND_FAIL;
            resp_type_reg <= psrb_pkg::RESP_TYPE_CODE;
        end else begin
            state_reg <= state_next;
            kind_reg <= kind_next;
            snap_reg <= snap_next;
            off_reg <= off_next;
            stype_reg <= stype_next;
            reason_reg <= reason_next;
            size_reg <= size_next;
            clr_snap_reg <= clr_snap_next;
            remote_memory_access_stats_flag_reg <= remote_memory_access_stats_flag_next;
            fc_flag_reg <= fc_flag_next;
            ib_flag_reg <= ib_flag_next;
            busy_reg <= busy_next;
            valid_reg <= valid_next;
            byte_reg <= byte_next;
            out_kind_reg <= out_kind_next;
            resp_type_reg <= psrb_pkg::RESP_TYPE_CODE;
        end
    end

    assign o_busy = busy_reg;
    assign o_valid = valid_reg;
    assign o_byte = byte_reg;
    assign o_resp_type = resp_type_reg;
    assign o_ib_cleared = {8'h00, ib_flag_reg};

    // The kind travels with the byte, since a new query may be taken while a last byte waits.
    wire beat = o_valid && i_ready;
    wire out_remote_memory_access_stats = (out_kind_reg == psrb_pkg::KIND_REMOTE_MEMORY_ACCESS_STATS);
    wire out_fc = (out_kind_reg == psrb_pkg::KIND_FC);

    a_remote_memory_access_stats_last: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        beat && o_byte.last && out_remote_memory_access_stats |-> o_byte.offset == psrb_pkg::REMOTE_MEMORY_ACCESS_STATS_LAST_BYTE)
        else $error("Remote memory response ends at the wrong byte.");
    a_fc_last: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        beat && o_byte.last && out_fc |-> o_byte.offset == psrb_pkg::FC_LAST_BYTE)
        else $error("Fibre link response ends at the wrong byte.");
    a_size_rsvd: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        o_valid && out_remote_memory_access_stats && o_byte.offset == psrb_pkg::SIZES_BYTE
        |-> o_byte.data == {1'b0, size_reg})
        else $error("Counter size byte is wrong.");
    a_fc_rsvd: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        o_valid && out_fc && o_byte.offset == psrb_pkg::SIZES_BYTE |-> o_byte.data == 8'h00)
        else $error("Fibre link byte 21 is not zero.");
    a_remote_memory_access_stats_clr_hi: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        o_valid && out_remote_memory_access_stats && o_byte.offset == psrb_pkg::CLR_HI_BYTE |-> o_byte.data == 8'h00)
        else $error("Remote memory cleared field upper bits set.");
    a_fc_clr_hi: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        o_valid && out_fc && o_byte.offset == psrb_pkg::CLR_HI_BYTE |-> o_byte.data[7:1] == 7'h00)
        else $error("Fibre link cleared field reserved bits set.");
    a_reason_ok: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        o_valid && out_remote_memory_access_stats && o_byte.offset[6:2] == psrb_pkg::CODE_WORD |-> o_byte.data == 8'h00)
        else $error("Successful response carries a nonzero code.");
    a_flag_set: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        i_clr_remote_memory_access_stats[0] |=> remote_memory_access_stats_flag_reg[0])
        else $error("Clear did not set its flag.");
    a_flag_hold: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        remote_memory_access_stats_flag_reg[0] && !(accept && !i_req_fail && i_req_type == STATS_REMOTE_MEMORY_ACCESS_STATS)
        |=> remote_memory_access_stats_flag_reg[0])
        else $error("Cleared flag lost before it was reported.");
    a_ib_set_wins: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        i_clr_ib[0] && i_ib_reported |=> o_ib_cleared[0])
        else $error("Clear lost against a report in the same cycle.");
    a_remote_memory_access_stats_accept: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        accept && !i_req_fail && i_req_type == STATS_REMOTE_MEMORY_ACCESS_STATS |=> o_busy ##[1:2] o_valid)
        else $error("Remote memory request not answered.");

    c_remote_memory_access_stats_done: cover property (@(posedge i_clock) disable iff (!i_rst_b)
        beat && o_byte.last && out_remote_memory_access_stats);
    c_fc_done: cover property (@(posedge i_clock) disable iff (!i_rst_b)
        beat && o_byte.last && out_fc);
    c_stall: cover property (@(posedge i_clock) disable iff (!i_rst_b)
        o_valid && !i_ready ##1 beat);

endmodule : psrb_builder

// ---- testbench/psrb_sink.sv ----
`timescale 1ns/100ps
// Management-side consumer; slow mode stalls every other cycle so held bytes get exercised.
module psrb_sink (
    input wire logic i_clock,
    input wire logic i_slow,
    input wire logic i_valid,
    input wire psrb_pkg::psrb_byte_type i_byte,
    output logic o_ready,
    output logic [7:0] o_mem [0:127],
    output int o_packets
);
    logic toggle_reg = 1'b0;
    int packets = 0;
    assign o_ready = ~i_slow | toggle_reg;
    assign o_packets = packets;
    always @(posedge i_clock) begin
        toggle_reg <= ~toggle_reg;
        if (i_valid && o_ready) begin
            o_mem[i_byte.offset] <= i_byte.data;
            if (i_byte.last) begin
                packets <= packets + 1;
            end
        end
    end
endmodule : psrb_sink

// ---- testbench/psrb_builder_test.sv ----
`timescale 1ns/100ps
module psrb_builder_test;
    logic i_clock = 1'b0;
    logic i_rst_b = 1'b0;
    logic req = 1'b0;
    logic [7:0] req_type = 8'h00;
    logic req_fail = 1'b0;
    logic [15:0] reason = 16'h0000;
    psrb_pkg::psrb_cnt_type counters = '0;
    logic [6:0] size64 = 7'h55;
    logic [6:0] clr_remote_memory_access_stats = 7'h00;
    logic [8:0] clr_fc = 9'h000;
    logic [7:0] clr_ib = 8'h00;
    logic ib_rep = 1'b0;
    logic slow = 1'b0;
    logic ready;
    logic valid;
    logic busy;
    psrb_pkg::psrb_byte_type obyte;
    logic [7:0] resp_type;
    logic [15:0] ib_cleared;
    logic [7:0] mem [0:127];
    logic [7:0] exp [0:127];
    int packets;
    int fail_count = 0;
    int n_compared = 0;

    always #4 i_clock = ~i_clock;

    psrb_builder i_dut (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_req(req),
        .i_req_type(req_type), .i_req_fail(req_fail), .i_req_reason(reason),
        .i_counters(counters), .i_remote_memory_access_stats_size64(size64), .i_clr_remote_memory_access_stats(clr_remote_memory_access_stats),
        .i_clr_fc(clr_fc), .i_clr_ib(clr_ib), .i_ib_reported(ib_rep), .i_ready(ready),
        .o_busy(busy), .o_valid(valid), .o_byte(obyte), .o_resp_type(resp_type),
        .o_ib_cleared(ib_cleared));

    psrb_sink i_sink (.i_clock(i_clock), .i_slow(slow), .i_valid(valid), .i_byte(obyte),
        .o_ready(ready), .o_mem(mem), .o_packets(packets));

    task automatic check(input logic [15:0] seen, input logic [15:0] expv);
        n_compared++;
        if (seen !== expv) begin
            fail_count++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, expv);
        end
    endtask : check

    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : conclude

    // Inputs change one nanosecond after the rising edge, never on it.
    task automatic tick(input int n);
        repeat (n) @(posedge i_clock);
        #1;
    endtask : tick

    task automatic put_word(input int b, input logic [31:0] w);
        for (int k = 0; k < 4; k++) begin
            exp[b + k] = w[31 - 8 * k -: 8];
        end
    endtask : put_word

    // Callers only issue after the previous last byte was taken, so the builder is idle.
    task automatic request(input logic [7:0] t, input logic f, input int last_off);
        int start;
        start = packets;
        req = 1'b1;
        req_type = t;
        req_fail = f;
        tick(1);
        req = 1'b0;
        // A clear lined up with the request lasts exactly the accepting edge.
        clr_remote_memory_access_stats = 7'h00;
        check(16'(busy), 16'h0001);
        for (int i = 0; i < 400 && packets == start; i++) begin
            tick(1);
        end
        if (packets == start) begin
            fail_count++;
            $display("ERROR %0t: no response to type %h", $time, t);
        end else begin
            check(16'(busy), 16'h0000);
            for (int b = 16; b <= last_off; b++) begin
                check(16'(mem[b]), 16'(exp[b]));
            end
        end
        $display("test done: type %h fail %b", t, f);
    endtask : request

    initial begin
        for (int i = 0; i < 9; i++) begin
            counters.value[i] = {4'ha, 4'(i), 24'h0a0b0c, 4'hb, 4'(i), 24'h010203};
        end
        tick(20);
        i_rst_b = 1'b1;
        tick(1);
        check(16'(resp_type), 16'h00af);
        clr_remote_memory_access_stats = 7'h2a;
        tick(1);
        clr_remote_memory_access_stats = 7'h00;
        put_word(16, 32'h0);
        put_word(20, {8'h01, 1'b0, size64, 16'h002a});
        for (int i = 0; i < 7; i++) begin
            put_word(24 + 8 * i, size64[i] ? counters.value[i][63:32] : 32'h0);
            put_word(28 + 8 * i, counters.value[i][31:0]);
        end
        request(8'h01, 1'b0, 79);
        // The first response reported the flags, so a second one must show them clear.
        exp[23] = 8'h00;
        // A clear on the reporting edge must win and show in the next report.
        clr_remote_memory_access_stats = 7'h01;
        request(8'h01, 1'b0, 79);
        exp[23] = 8'h01;
        request(8'h01, 1'b0, 79);
        slow = 1'b1;
        clr_fc = 9'h181;
        tick(1);
        clr_fc = 9'h000;
        put_word(20, {8'h02, 8'h00, 16'h0181});
        for (int i = 0; i < 9; i++) begin
            put_word(24 + 4 * i, counters.value[i][31:0]);
        end
        request(8'h02, 1'b0, 59);
        slow = 1'b0;
        reason = 16'h0005;
        put_word(16, 32'h00010005);
        request(8'h01, 1'b1, 19);
        request(8'h07, 1'b0, 19);
        clr_ib = 8'h81;
        tick(1);
        clr_ib = 8'h00;
        tick(1);
        check(ib_cleared, 16'h0081);
        ib_rep = 1'b1;
        tick(1);
        ib_rep = 1'b0;
        tick(1);
        check(ib_cleared, 16'h0000);
        clr_ib = 8'h01;
        ib_rep = 1'b1;
        tick(1);
        clr_ib = 8'h00;
        ib_rep = 1'b0;
        check(ib_cleared, 16'h0001);
        $display("test done: cleared field");
        conclude();
    end
endmodule : psrb_builder_test
